// ==== logic/pclp_pkg.sv ====
// Package for the parallel configuration load port.
// Assumes a 100 MHz system clock; all timings derive from it.
package pclp_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int DATA_W = 32;
    // Data width modes
    localparam logic [1:0] WIDTH_X8 = 2'h0;
    localparam logic [1:0] WIDTH_X16 = 2'h1;
    localparam logic [1:0] WIDTH_X32 = 2'h2;
    // Times as printed
    localparam int CF2ST0_MAX_NS = 600;
    localparam int STATUS_MIN_US = 268;
    localparam int STATUS_MAX_US = 1506;
    localparam int CD2UM_MIN_US = 175;
    localparam int CD2UM_MAX_US = 437;
    // Derived cycle counts
    localparam int STATUS_MIN_CYC = (STATUS_MIN_US * 1000 + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int STATUS_MAX_CYC = STATUS_MAX_US * 1000 / CLK_PERIOD_NS;
    localparam int CD2UM_MIN_CYC = (CD2UM_MIN_US * 1000 + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int CD2UM_MAX_CYC = CD2UM_MAX_US * 1000 / CLK_PERIOD_NS;
    localparam int CNT_W = 20;
    localparam logic [3:0] INIT_EDGES = 4'h2;

    typedef struct packed {
        logic [1:0] width;
        logic decompress;
        logic decrypt;
    } pclp_mode_s;

    typedef enum logic [4:0] {
        ST_POR    = 5'h01,
        ST_RESET  = 5'h02,
        ST_LOAD   = 5'h04,
        ST_INIT   = 5'h08,
        ST_USER   = 5'h10
    } pclp_state_e;
endpackage

// ==== logic/pclp_load_port.sv ====
// Device side of the parallel configuration load port.
// Assumes config pins are asynchronous; they pass two flops first.
// Functional notes
// - Ratio per 8/16-bit mode and features
// - Ratio per 32-bit mode and features
// - Active lanes follow selected width
// - Data pins released after configuration
// - Request falling edge starts reconfiguration
// - Status low during power-on delay
// - Completion low before and during load
// - Completion rises after all data received
// - Config clock ignored in user mode
// - Init-done pin driven low during init once enabled
// - Completion low within 600 ns
// - Status low within 600 ns
// - Status low 268 to 1506 us
// - Status high within 1506 us
// - Words captured on rising config clock
// - User mode 175 to 437 us later
`timescale 1ns/100ps
module pclp_load_port #(
    parameter int POR_CYC = 1000,
    parameter int STATUS_CYC = pclp_pkg::STATUS_MIN_CYC + 100,
    parameter int INIT_CYC = pclp_pkg::CD2UM_MIN_CYC + 100,
    parameter int WORDS = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire pclp_pkg::pclp_mode_s mode,
    input wire logic init_done_en,
    input wire logic config_clock,
    input wire logic config_req_n,
    input wire logic [pclp_pkg::DATA_W-1:0] data_in,
    output logic status_n,
    output logic config_complete_flag,
    output logic user_mode,
    output logic init_done_n,
    output logic init_done_oe,
    output logic data_user_en,
    output logic word_valid,
    output logic [pclp_pkg::DATA_W-1:0] word_data
);
    logic [2:0] clk_sync_q;
    logic [1:0] req_sync_q;
    logic req_prev_q;
    logic [pclp_pkg::DATA_W-1:0] data_s1_q, data_s2_q;
    pclp_pkg::pclp_mode_s mode_s1_q;
    pclp_pkg::pclp_mode_s mode_q;
    logic [1:0] init_en_sync_q;
    pclp_pkg::pclp_state_e state_q;
    logic [pclp_pkg::CNT_W-1:0] cnt_q;
    logic [3:0] phase_q;
    logic [15:0] words_q;
    logic [3:0] fall_q;
    logic req_low_q;

    function automatic logic [3:0] ratio(input pclp_pkg::pclp_mode_s m);
        unique case (m.width)
            pclp_pkg::WIDTH_X8: ratio = m.decompress ? 4'h2 : 4'h1;
            pclp_pkg::WIDTH_X16: ratio = m.decompress ? 4'h4 :
                (m.decrypt ? 4'h2 : 4'h1);
            default: ratio = m.decompress ? 4'h8 :
                (m.decrypt ? 4'h4 : 4'h1);
        endcase
    endfunction

    function automatic logic [pclp_pkg::DATA_W-1:0] lanes(
        input logic [1:0] w, input logic [pclp_pkg::DATA_W-1:0] d);
        unique case (w)
            pclp_pkg::WIDTH_X8: lanes = {24'h000000, d[7:0]};
            pclp_pkg::WIDTH_X16: lanes = {16'h0000, d[15:0]};
            default: lanes = d;
        endcase
    endfunction

    wire cclk_rise = clk_sync_q[1] & ~clk_sync_q[2];
    wire cclk_fall = ~clk_sync_q[1] & clk_sync_q[2];
    wire req_fall = req_prev_q & ~req_sync_q[1];

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            clk_sync_q <= 3'h0;
            req_sync_q <= 2'h3;
            req_prev_q <= 1'b1;
            data_s1_q <= '0;
            data_s2_q <= '0;
            mode_s1_q <= '0;
            mode_q <= '0;
            init_en_sync_q <= 2'h0;
        end
        else
        begin
            clk_sync_q <= {clk_sync_q[1:0], config_clock};
            req_sync_q <= {req_sync_q[0], config_req_n};
            req_prev_q <= req_sync_q[1];
            data_s1_q <= data_in;
            data_s2_q <= data_s1_q;
            mode_s1_q <= mode;
            mode_q <= mode_s1_q;
            init_en_sync_q <= {init_en_sync_q[0], init_done_en};
        end
    end

    // Main sequence
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_q <= pclp_pkg::ST_POR;
            cnt_q <= '0;
            phase_q <= 4'h0;
            words_q <= 16'h0000;
            fall_q <= 4'h0;
            req_low_q <= 1'b0;
        end
        else if (req_fall)
        begin
            state_q <= pclp_pkg::ST_RESET;
            cnt_q <= '0;
            req_low_q <= 1'b1;
        end
        else
        begin
            unique case (state_q)
                pclp_pkg::ST_POR:
                begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == pclp_pkg::CNT_W'(POR_CYC - 1))
                    begin
                        state_q <= pclp_pkg::ST_LOAD;
                        cnt_q <= '0;
                    end
                end
                pclp_pkg::ST_RESET:
                begin
                    if (req_sync_q[1])
                        req_low_q <= 1'b0;
                    if (cnt_q != pclp_pkg::CNT_W'(STATUS_CYC - 1))
                        cnt_q <= cnt_q + 1'b1;
                    else if (req_sync_q[1] && !req_low_q)
                    begin
                        state_q <= pclp_pkg::ST_LOAD;
                        cnt_q <= '0;
                        phase_q <= 4'h0;
                        words_q <= 16'h0000;
                    end
                end
                pclp_pkg::ST_LOAD:
                begin
                    if (cclk_rise)
                    begin
                        phase_q <= (phase_q == ratio(mode_q) - 4'h1) ? 4'h0
                            : phase_q + 4'h1;
                        if (phase_q == 4'h0)
                        begin
                            words_q <= words_q + 16'h0001;
                            if (words_q == 16'(WORDS - 1))
                            begin
                                state_q <= pclp_pkg::ST_INIT;
                                fall_q <= 4'h0;
                                cnt_q <= '0;
                            end
                        end
                    end
                end
                pclp_pkg::ST_INIT:
                begin
                    if (cclk_fall && fall_q != pclp_pkg::INIT_EDGES)
                        fall_q <= fall_q + 4'h1;
                    if (fall_q == pclp_pkg::INIT_EDGES)
                        cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == pclp_pkg::CNT_W'(INIT_CYC - 1))
                        state_q <= pclp_pkg::ST_USER;
                end
                pclp_pkg::ST_USER:
                    cnt_q <= '0;
            endcase
        end
    end

    // Outputs, all registered
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            status_n <= 1'b0;
            config_complete_flag <= 1'b0;
            user_mode <= 1'b0;
            init_done_n <= 1'b1;
            init_done_oe <= 1'b0;
            data_user_en <= 1'b0;
            word_valid <= 1'b0;
            word_data <= '0;
        end
        else
        begin
            status_n <= !(state_q == pclp_pkg::ST_POR ||
                state_q == pclp_pkg::ST_RESET) && !req_fall;
            config_complete_flag <= (state_q == pclp_pkg::ST_INIT ||
                state_q == pclp_pkg::ST_USER) && !req_fall;
            user_mode <= state_q == pclp_pkg::ST_USER && !req_fall;
            init_done_oe <= init_en_sync_q[1] &&
                state_q == pclp_pkg::ST_INIT && !req_fall;
            init_done_n <= !(init_en_sync_q[1] &&
                state_q == pclp_pkg::ST_INIT);
            data_user_en <= state_q == pclp_pkg::ST_USER && !req_fall;
            word_valid <= state_q == pclp_pkg::ST_LOAD && cclk_rise &&
                phase_q == 4'h0 && !req_fall;
            if (state_q == pclp_pkg::ST_LOAD && cclk_rise && phase_q == 4'h0)
                word_data <= lanes(mode_q.width, data_s2_q);
        end
    end

    int status_lo_cnt;
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            status_lo_cnt <= 0;
        else if (status_n)
            status_lo_cnt <= 0;
        else if (state_q == pclp_pkg::ST_RESET)
            status_lo_cnt <= status_lo_cnt + 1;
    end

    chk_status_on_req: assert property (@(posedge clk) disable iff (reset)
        req_fall |-> ##[1:2] !status_n)
        else $error("status not low after request fall");
    chk_complete_on_req: assert property (@(posedge clk) disable iff (reset)
        req_fall |-> ##1 !config_complete_flag)
        else $error("completion not low after request fall");
    chk_status_min_len: assert property (@(posedge clk) disable iff (reset)
        $rose(status_n) && status_lo_cnt > 0 |->
        status_lo_cnt >= STATUS_CYC - 1)
        else $error("status low pulse too short");
    chk_complete_load: assert property (@(posedge clk) disable iff (reset)
        state_q == pclp_pkg::ST_LOAD |-> ##1
        (!config_complete_flag || req_fall))
        else $error("completion high during load");
    chk_por_status: assert property (@(posedge clk) disable iff (reset)
        state_q == pclp_pkg::ST_POR |-> ##1 !status_n)
        else $error("status high during power-on delay");
    chk_user_pins: assert property (@(posedge clk) disable iff (reset)
        data_user_en |-> config_complete_flag && user_mode)
        else $error("data pins released before user mode");
    chk_word_lanes: assert property (@(posedge clk) disable iff (reset)
        word_valid && $past(mode_q.width) == pclp_pkg::WIDTH_X8 |->
        word_data[31:8] == 24'h000000)
        else $error("inactive lanes captured");
    chk_init_pin: assert property (@(posedge clk) disable iff (reset)
        init_done_oe |-> !init_done_n && config_complete_flag)
        else $error("init pin not driven low");
    chk_ratio_x32: assert property (@(posedge clk) disable iff (reset)
        mode_q.width == pclp_pkg::WIDTH_X32 && mode_q.decompress |->
        ratio(mode_q) == 4'h8)
        else $error("wide ratio wrong");
    chk_user_idle: assert property (@(posedge clk) disable iff (reset)
        state_q == pclp_pkg::ST_USER && !req_fall |=> state_q ==
        pclp_pkg::ST_USER)
        else $error("config clock disturbed user mode");

    cov_reconfig: cover property (@(posedge clk) disable iff (reset)
        req_fall ##1 state_q == pclp_pkg::ST_RESET);
    cov_word: cover property (@(posedge clk) disable iff (reset) word_valid);
    cov_done: cover property (@(posedge clk) disable iff (reset)
        $rose(config_complete_flag));
    cov_user: cover property (@(posedge clk) disable iff (reset)
        $rose(user_mode));
endmodule

// ==== bench/pclp_host.sv ====
// Host model that loads the port: request, config clock and data bus.
// Assumes the bench calls its tasks; delays are in ns, unrelated to clk.
`timescale 1ns/100ps
module pclp_host (
    output logic config_clock,
    output logic config_req_n,
    output logic [pclp_pkg::DATA_W-1:0] data_in
);
    initial
    begin
        config_clock = 1'b0;
        config_req_n = 1'b1;
        data_in = 32'h0;
    end

    // One 125 ns clock period, idle low between frames
    task automatic pulse();
        #62.5 config_clock = 1'b1;
        #62.5 config_clock = 1'b0;
    endtask

    task automatic request();
        config_req_n = 1'b0;
        #2000 config_req_n = 1'b1;
    endtask

    // Word changes after a fall and holds for ratio rises
    task automatic send(input logic [31:0] w, input int r);
        data_in = w;
        repeat (r) pulse();
    endtask

    task automatic finish(input int r);
        repeat (r - 1) pulse();
        data_in = ~data_in;
    endtask
endmodule

// ==== bench/tb.sv ====
// Testbench for the load port: all width and feature modes in turn.
// Assumes the host model drives the config pins; bench drives mode.
`timescale 1ns/100ps
module tb;
    localparam int WORDS = 4;
    logic clk = 1'b0;
    logic reset = 1'b1;
    pclp_pkg::pclp_mode_s mode = '0;
    logic init_done_en = 1'b0;
    logic config_clock;
    logic config_req_n;
    logic [31:0] data_in;
    logic [31:0] word_data;
    logic status_n;
    logic config_complete_flag;
    logic user_mode;
    logic init_done_n;
    logic init_done_oe;
    logic data_user_en;
    logic word_valid;
    int bad_count = 0;
    int n_compared = 0;
    int seed = 23788;
    logic [31:0] exp_q[$];

    always #5 clk = ~clk;

    pclp_load_port #(.POR_CYC(10), .STATUS_CYC(20), .INIT_CYC(20),
        .WORDS(WORDS)) pclp_load_port_i (
        .clk(clk), .reset(reset), .mode(mode),
        .init_done_en(init_done_en), .config_clock(config_clock),
        .config_req_n(config_req_n), .data_in(data_in),
        .status_n(status_n), .config_complete_flag(config_complete_flag),
        .user_mode(user_mode), .init_done_n(init_done_n),
        .init_done_oe(init_done_oe), .data_user_en(data_user_en),
        .word_valid(word_valid), .word_data(word_data));

    pclp_host pclp_host_i (.config_clock(config_clock),
        .config_req_n(config_req_n), .data_in(data_in));

    task automatic cmp(input string what, input logic [31:0] e,
        input logic [31:0] s);
        n_compared++;
        if (s !== e)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic wait_lvl(ref logic s, input logic v, input int lim,
        input string what);
        int n;
        n = 0;
        while (s !== v && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        cmp(what, 32'(v), 32'(s));
    endtask

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    function automatic int ratio(input pclp_pkg::pclp_mode_s m);
        if (m.width == pclp_pkg::WIDTH_X8)
            return m.decompress ? 2 : 1;
        if (m.width == pclp_pkg::WIDTH_X16)
            return m.decompress ? 4 : (m.decrypt ? 2 : 1);
        return m.decompress ? 8 : (m.decrypt ? 4 : 1);
    endfunction

    function automatic logic [31:0] mask(input pclp_pkg::pclp_mode_s m);
        if (m.width == pclp_pkg::WIDTH_X8)
            return 32'h000000FF;
        if (m.width == pclp_pkg::WIDTH_X16)
            return 32'h0000FFFF;
        return 32'hFFFFFFFF;
    endfunction

    // Each captured word is matched against the oldest noted word
    always @(posedge clk)
        if (word_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                cmp("word_extra", 32'h0, 32'h1);
            else
                cmp("word", exp_q.pop_front(), word_data);
        end

    initial
    begin
        pclp_pkg::pclp_mode_s m;
        logic [31:0] w;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        cmp("status_por", 32'h0, 32'(status_n));
        wait_lvl(status_n, 1'b1, 100, "status_up");
        cmp("flag_por", 32'h0, 32'(config_complete_flag));
        for (int i = 0; i < 12; i++)
        begin
            m.width = 2'(i / 4);
            m.decompress = i[1];
            m.decrypt = i[0];
            fork
                pclp_host_i.request();
                begin
                    #600;
                    cmp("status_low", 32'h0, 32'(status_n));
                    cmp("flag_low", 32'h0, 32'(config_complete_flag));
                    @(posedge clk);
                    mode <= m;
                    init_done_en <= i[0];
                end
            join
            wait_lvl(status_n, 1'b1, 1000, "status_rel");
            #2000;
            for (int k = 0; k < WORDS; k++)
            begin
                w = $random(seed);
                exp_q.push_back(w & mask(m));
                cmp("flag_load", 32'h0, 32'(config_complete_flag));
                fork
                    begin
                        pclp_host_i.send(w, ratio(m));
                        if (k == WORDS - 1)
                            pclp_host_i.finish(ratio(m));
                    end
                    if (k == WORDS - 1)
                    begin
                        wait_lvl(config_complete_flag, 1'b1, 100,
                            "flag_done");
                        cmp("init_pin", {30'h0, i[0], ~i[0]},
                            {30'h0, init_done_oe, init_done_n});
                    end
                join
            end
            repeat (2) pclp_host_i.pulse();
            wait_lvl(user_mode, 1'b1, 200, "user_mode");
            cmp("data_user", 32'h1, 32'(data_user_en));
            pclp_host_i.send($random(seed), 3);
            cmp("words_left", 32'h0, 32'(exp_q.size()));
            $display("test mode %0d done", i);
        end
        wrap_up();
    end

    initial
    begin
        #400000;
        bad_count++;
        wrap_up();
    end
endmodule
